// [core/lcd_control_defines.vh]
// Constants for the segment LCD display controller
`ifndef LCD_CONTROL_DEFINES_VH
`define LCD_CONTROL_DEFINES_VH

// Control register field positions
`define LCD_CONTROL_BANK_BIT       0
`define LCD_CONTROL_SRC_BIT        1
`define LCD_CONTROL_LATCH_EN_BIT   2
`define LCD_CONTROL_OUT_EN_BIT     3
`define LCD_CONTROL_CTRL_RESET     4'hc

// Display memory window
`define LCD_CONTROL_DISP_LO        8'hb0
`define LCD_CONTROL_DISP_HI        8'hff
`define LCD_CONTROL_NUM_SEG        40
`define LCD_CONTROL_NUM_COM        16
`define LCD_CONTROL_COMS_PER_BANK  8

// Clock division: crystal 32768 Hz to 16384 Hz base is /2, system /64
`define LCD_CONTROL_XTAL_BASE_DIV  2
`define LCD_CONTROL_SYS_BASE_DIV   64
`define LCD_CONTROL_XTAL_N_DEF     0
`define LCD_CONTROL_SYS_N_DEF      0

// Bias levels for 1/4 bias, coded as level index 0..4
`define LCD_CONTROL_LVL_W          3
`define LCD_CONTROL_LVL_GND        3'h0
`define LCD_CONTROL_LVL_Q1         3'h1
`define LCD_CONTROL_LVL_Q3         3'h3
`define LCD_CONTROL_LVL_TOP        3'h4

`endif

// [core/lcd_control_tick_gen.v]
// LCD scan tick generator with selectable source and build-time division
`timescale 1ns/100ps
`default_nettype none
`include "lcd_control_defines.vh"

module lcd_control_tick_gen #(
  parameter XTAL_N = `LCD_CONTROL_XTAL_N_DEF,
  parameter SYS_N  = `LCD_CONTROL_SYS_N_DEF
) (
  input  wire mclk,
  input  wire reset,
  input  wire src_sys,
  input  wire xtal_edge,
  output reg  tick
);

  // Terms worked out at full width, then cut to the counter's 16 bits
  localparam integer XTAL_TERM_I = `LCD_CONTROL_XTAL_BASE_DIV << XTAL_N;
  localparam integer SYS_TERM_I  = `LCD_CONTROL_SYS_BASE_DIV << SYS_N;
  localparam [15:0]  XTAL_TERM   = XTAL_TERM_I[15:0];
  localparam [15:0]  SYS_TERM    = SYS_TERM_I[15:0];

  reg [15:0] div_reg;
  reg [15:0] div_next;
  reg        tick_next;
  reg        src_d_reg;

  // Count crystal edges or system cycles; restart on source change
  always @* begin
    div_next  = div_reg;
    tick_next = 1'b0;
    if (src_sys != src_d_reg) begin
      div_next = 16'h0000;
    end else if (src_sys || xtal_edge) begin
      if (div_reg == (src_sys ? SYS_TERM : XTAL_TERM) - 16'h0001) begin
        div_next  = 16'h0000;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 16'h0001;
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      div_reg   <= 16'h0000;
      tick      <= 1'b0;
      src_d_reg <= 1'b0;
    end else begin
      div_reg   <= div_next;
      tick      <= tick_next;
      src_d_reg <= src_sys;
    end
  end

endmodule
`default_nettype wire

// [core/lcd_control_display.v]
// Segment LCD controller: control register, display memory, scan and latch
//
// Functional notes
// - Control bit 0 selects which display bank drives commons 0-7 or 8-15.
// - Control bit 1 picks crystal (0) or system clock (1) as LCD source.
// - Control bit 3 high enables segment and common driving, low disables.
// - Output enable never alters display memory contents.
// - Crystal source gives 16384 Hz over two to the n, n 0-7.
// - System source gives system frequency over 64 over two to the n.
// - Forty segments, sixteen commons, 1/16 duty, 1/4 bias.
// - Display memory read and written like ordinary data memory.
// - Optional falling-edge latch on input pin three of second port.
// - Latch cleared when control bit 2 goes 1 to 0, unless a fall arrives in that cycle; bit enables latch.
// - Display data lives at B0-FF of two banks, fetched automatically.
`timescale 1ns/100ps
`default_nettype none
`include "lcd_control_defines.vh"

module lcd_control_display #(
  parameter XTAL_N      = `LCD_CONTROL_XTAL_N_DEF,
  parameter SYS_N       = `LCD_CONTROL_SYS_N_DEF,
  parameter LATCH_OPTION = 1
) (
  input  wire        mclk,
  input  wire        reset,
  input  wire        ctrl_wr,
  input  wire [3:0]  ctrl_wdata,
  output reg  [3:0]  lcd_control,
  input  wire        mem_wr,
  input  wire        mem_rd,
  input  wire        mem_bank,
  input  wire [7:0]  mem_addr,
  input  wire [3:0]  mem_wdata,
  output reg  [3:0]  mem_rdata,
  output reg         mem_hit,
  input  wire        crystal_32k_clock,
  input  wire        latch_pin,
  output reg         edge_latched_input,
  output reg  [119:0] seg_level,
  output reg  [47:0]  com_level,
  output reg  [3:0]   active_com
);

  localparam NSEG = `LCD_CONTROL_NUM_SEG;
  localparam NCOM = `LCD_CONTROL_NUM_COM;
  localparam LW   = `LCD_CONTROL_LVL_W;
  localparam DEPTH = 160; // Two banks of 80 nibbles, B0..FF

  // Display memory; no reset, contents random at power-up
  reg [3:0] disp_mem [0:DEPTH-1];

  reg [1:0] xtal_sync_reg;
  reg       xtal_d_reg;
  reg [1:0] pin_sync_reg;
  reg       pin_d_reg;
  reg [3:0] scan_reg;
  reg [3:0] scan_next;
  reg       frame_reg;
  reg       frame_next;
  reg [3:0] ctrl_next;
  reg [3:0] rdata_next;
  reg       hit_next;
  reg       latch_next;
  wire      latch_clear;
  wire      tick;
  wire      xtal_edge;
  wire      pin_fall;
  wire      mem_in_range;
  wire [7:0] mem_index;

  // True when an address falls in the display window
  function in_window;
    input [7:0] a;
    begin
      in_window = (a >= `LCD_CONTROL_DISP_LO) && (a <= `LCD_CONTROL_DISP_HI);
    end
  endfunction

  // Linear index: bank times 80 plus offset into window
  function [7:0] mem_idx;
    input       b;
    input [7:0] a;
    reg   [7:0] off;
    begin
      off     = a - `LCD_CONTROL_DISP_LO;
      mem_idx = (b ? 8'h50 : 8'h00) + off;
    end
  endfunction

  // Segment level; polarity flips each frame to keep the panel DC-free
  function [LW-1:0] seg_drive;
    input on;
    input frm;
    begin
      if (on) begin
        seg_drive = frm ? `LCD_CONTROL_LVL_TOP : `LCD_CONTROL_LVL_GND;
      end else begin
        seg_drive = frm ? `LCD_CONTROL_LVL_Q1 : `LCD_CONTROL_LVL_Q3;
      end
    end
  endfunction

  // Common level: scanned common at a rail, the rest at one or three quarters
  function [LW-1:0] com_drive;
    input sel;
    input frm;
    begin
      if (sel) begin
        com_drive = frm ? `LCD_CONTROL_LVL_GND : `LCD_CONTROL_LVL_TOP;
      end else begin
        com_drive = frm ? `LCD_CONTROL_LVL_Q3 : `LCD_CONTROL_LVL_Q1;
      end
    end
  endfunction

  assign mem_in_range = in_window(mem_addr);
  assign mem_index    = mem_idx(mem_bank, mem_addr);

  // Control fields by name; bank select and output enable steer the drive
  wire      lcd_bank_select;
  wire      lcd_src_system;
  wire      lcd_latch_enable;
  wire      lcd_output_enable;
  assign lcd_bank_select   = lcd_control[`LCD_CONTROL_BANK_BIT];
  assign lcd_src_system    = lcd_control[`LCD_CONTROL_SRC_BIT];
  assign lcd_latch_enable  = lcd_control[`LCD_CONTROL_LATCH_EN_BIT];
  assign lcd_output_enable = lcd_control[`LCD_CONTROL_OUT_EN_BIT];

  // Next control value; only the accumulator move strobe loads it
  always @* begin
    ctrl_next = lcd_control;
    if (ctrl_wr) begin
      ctrl_next = ctrl_wdata;
    end
  end

  // Control register; reset leaves the panel on and the latch armed
  always @(posedge mclk) begin
    if (reset) begin
      lcd_control <= `LCD_CONTROL_CTRL_RESET;
    end else begin
      lcd_control <= ctrl_next;
    end
  end

  // Core access path, same timing as data memory: one-cycle read
  always @(posedge mclk) begin
    if (mem_wr && mem_in_range) begin
      disp_mem[mem_index] <= mem_wdata;
    end
  end

  // Read answer; addresses outside the window read as zero, no hit
  always @* begin
    hit_next   = (mem_rd || mem_wr) && mem_in_range;
    rdata_next = 4'h0;
    if (mem_rd && mem_in_range) begin
      rdata_next = disp_mem[mem_index];
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      mem_rdata <= 4'h0;
      mem_hit   <= 1'b0;
    end else begin
      mem_hit   <= hit_next;
      mem_rdata <= rdata_next;
    end
  end

  // Crystal and pin inputs come from outside; two flops first
  always @(posedge mclk) begin
    if (reset) begin
      xtal_sync_reg <= 2'b00;
      xtal_d_reg    <= 1'b0;
      pin_sync_reg  <= 2'b11; // Idle high: no false fall after reset
      pin_d_reg     <= 1'b1;
    end else begin
      xtal_sync_reg <= {xtal_sync_reg[0], crystal_32k_clock};
      xtal_d_reg    <= xtal_sync_reg[1];
      pin_sync_reg  <= {pin_sync_reg[0], latch_pin};
      pin_d_reg     <= pin_sync_reg[1];
    end
  end

  // Crystal must be well below mclk for edge sampling to be exact
  assign xtal_edge = xtal_sync_reg[1] & ~xtal_d_reg;
  assign pin_fall  = ~pin_sync_reg[1] & pin_d_reg;

  lcd_control_tick_gen #(
    .XTAL_N (XTAL_N),
    .SYS_N  (SYS_N)
  ) u_tick (
    .mclk      (mclk),
    .reset     (reset),
    .src_sys   (lcd_src_system),
    .xtal_edge (xtal_edge),
    .tick      (tick)
  );

  // Clear request: latch enable written from one to zero
  assign latch_clear = ctrl_wr && lcd_latch_enable &&
                       !ctrl_wdata[`LCD_CONTROL_LATCH_EN_BIT];

  // Edge latch; a fall in the clearing cycle still sets it, so no
  // edge is lost to a clear that software issues at the same time
  always @* begin
    latch_next = edge_latched_input;
    if (LATCH_OPTION != 0 && lcd_latch_enable && pin_fall) begin
      latch_next = 1'b1;
    end else if (latch_clear) begin
      latch_next = 1'b0;
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      edge_latched_input <= 1'b0;
    end else begin
      edge_latched_input <= latch_next;
    end
  end

  // Scan counter runs regardless of output enable, so switching the
  // panel back on picks up mid-frame with no restart
  always @* begin
    scan_next  = scan_reg;
    frame_next = frame_reg;
    if (tick) begin
      scan_next = scan_reg + 4'h1;
      if (scan_reg == 4'hf) begin
        frame_next = ~frame_reg; // Frame inversion keeps panel DC-free
      end
    end
  end

  always @(posedge mclk) begin
    if (reset) begin
      scan_reg  <= 4'h0;
      frame_reg <= 1'b0;
    end else begin
      scan_reg  <= scan_next;
      frame_reg <= frame_next;
    end
  end

  // Segment drive: bit of the selected bank for the active common
  genvar s;
  generate
    for (s = 0; s < NSEG; s = s + 1) begin : g_seg
      localparam integer SEG_NIB_I = 2 * s;
      localparam [7:0]   SEG_NIB   = SEG_NIB_I[7:0];
      wire       row_hit;
      wire [7:0] nib_addr;
      wire [7:0] nib_idx;
      wire       on_bit;
      // Each segment owns two nibbles: commons 0-3 and 4-7 of a bank
      assign row_hit  = (scan_reg[3] == lcd_bank_select);
      assign nib_addr = `LCD_CONTROL_DISP_LO + SEG_NIB + {7'h00, scan_reg[2]};
      assign nib_idx  = mem_idx(lcd_bank_select, nib_addr);
      assign on_bit   = row_hit & disp_mem[nib_idx][scan_reg[1:0]];
      always @(posedge mclk) begin
        if (reset) begin
          seg_level[s*LW +: LW] <= `LCD_CONTROL_LVL_GND;
        end else if (!lcd_output_enable) begin
          seg_level[s*LW +: LW] <= `LCD_CONTROL_LVL_GND;
        end else begin
          seg_level[s*LW +: LW] <= seg_drive(on_bit, frame_reg);
        end
      end
    end
  endgenerate

  // Common drive: selected common at rail, others at quarter levels
  genvar c;
  generate
    for (c = 0; c < NCOM; c = c + 1) begin : g_com
      always @(posedge mclk) begin
        if (reset) begin
          com_level[c*LW +: LW] <= `LCD_CONTROL_LVL_GND;
        end else if (!lcd_output_enable) begin
          com_level[c*LW +: LW] <= `LCD_CONTROL_LVL_GND;
        end else begin
          com_level[c*LW +: LW] <= com_drive(scan_reg == c, frame_reg);
        end
      end
    end
  endgenerate

  // Scan index, delayed to line up with the levels it names
  always @(posedge mclk) begin
    if (reset) begin
      active_com <= 4'h0;
    end else begin
      active_com <= scan_reg;
    end
  end

endmodule
`default_nettype wire

// [testbench/lcd_control_monitor.sv]
// Port checker for the LCD display controller
`timescale 1ns/100ps
`default_nettype none
module lcd_control_monitor (
  input wire logic         mclk,
  input wire logic         reset,
  input wire logic         ctrl_wr,
  input wire logic [3:0]   ctrl_wdata,
  input wire logic [3:0]   lcd_control,
  input wire logic         mem_wr,
  input wire logic         mem_rd,
  input wire logic [7:0]   mem_addr,
  input wire logic [3:0]   mem_rdata,
  input wire logic         mem_hit,
  input wire logic         edge_latched_input,
  input wire logic [119:0] seg_level,
  input wire logic [47:0]  com_level,
  input wire logic [3:0]   active_com
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Control register and display memory port
  a_ctrl_load: assert property (ctrl_wr |=> lcd_control == $past(ctrl_wdata))
    else $error("control load wrong");
  a_ctrl_hold: assert property (!ctrl_wr |=> $stable(lcd_control))
    else $error("control changed without write");
  a_rd_refuse: assert property (mem_rd && mem_addr < 8'hb0 |=> mem_rdata == 4'h0 && !mem_hit)
    else $error("read below window answered");
  a_hit_window: assert property ((mem_rd || mem_wr) && mem_addr >= 8'hb0 |=> mem_hit)
    else $error("window access not acknowledged");
  // Scan and drive; three off cycles cover the one-cycle output lag
  a_off_dark: assert property (!lcd_control[3] [*3] |-> seg_level == 120'h0 && com_level == 48'h0)
    else $error("panel driven while off");
  a_com_step: assert property (active_com != $past(active_com) |-> active_com == $past(active_com) + 4'h1)
    else $error("common skipped");
  a_com_gap: assert property ($changed(active_com) |=> $stable(active_com) [*8])
    else $error("common stepped too fast");
  // Edge latch
  a_latch_idle: assert property (!edge_latched_input && !lcd_control[2] |=> !edge_latched_input)
    else $error("latch set while disabled");
  a_latch_hold: assert property (edge_latched_input && lcd_control[2] && !ctrl_wr |=> edge_latched_input)
    else $error("latch dropped");
  c_off_on: cover property (!lcd_control[3] ##1 lcd_control[3]);
  c_latch: cover property ($rose(edge_latched_input));
  c_refuse: cover property (mem_rd && mem_addr < 8'hb0);
endmodule
bind lcd_control_display lcd_control_monitor u_mon (.*);
`default_nettype wire

// [testbench/lcd_control_panel.sv]
// Passive 40 by 16 panel model: reports which commons show lit pixels
`timescale 1ns/100ps
`default_nettype none
module lcd_control_panel (
  input  wire logic [119:0] seg_level,
  input  wire logic [47:0]  com_level,
  output var  logic [15:0]  lit_row,
  output var  logic [7:0]   lit_cnt
);
  // Only a full four-step swing lights a pixel; half-select stays dark
  always @* begin
    lit_row = 16'h0;
    lit_cnt = 8'h0;
    for (int c = 0; c < 16; c++) begin
      for (int s = 0; s < 40; s++) begin
        if (seg_level[3*s +: 3] - com_level[3*c +: 3] == 3'h4) begin
          lit_row[c] = 1'b1;
          lit_cnt = lit_cnt + 8'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Self-checking bench for the LCD display controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic         mclk = 0, reset = 1, ctrl_wr = 0, mem_wr = 0, mem_rd = 0, mem_bank = 0;
  logic         crystal_32k_clock = 0, latch_pin = 1, mem_hit, edge_latched_input;
  logic [3:0]   ctrl_wdata = 4'h0, mem_wdata = 4'h0, lcd_control, mem_rdata, active_com;
  logic [7:0]   mem_addr = 8'h0, lit_cnt;
  logic [119:0] seg_level;
  logic [47:0]  com_level;
  logic [15:0]  lit_row;
  int           n_errors = 0, samples_checked = 0;
  // Main clock and a slow crystal, 20 cycles per crystal period
  always #5 mclk = ~mclk;
  always #100 crystal_32k_clock = ~crystal_32k_clock;
  lcd_control_display #(.XTAL_N(1), .SYS_N(0), .LATCH_OPTION(1)) DUT (.*);
  lcd_control_panel PANEL (.*);
  task automatic check(input logic [119:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ctrl(input logic [3:0] v);
    @(negedge mclk);
    ctrl_wr = 1;
    ctrl_wdata = v;
    @(negedge mclk);
    ctrl_wr = 0;
  endtask
  task automatic mem(input logic w, b, input logic [7:0] a, input logic [3:0] d);
    @(negedge mclk);
    {mem_wr, mem_rd, mem_bank, mem_addr, mem_wdata} = {w, !w, b, a, d};
    @(negedge mclk);
    {mem_wr, mem_rd} = 2'b00;
  endtask
  // Cycles between two common steps, bounded
  task automatic step_gap(input int exp);
    logic [3:0] p;
    int n;
    p = active_com;
    n = 0;
    for (int i = 0; i < 300 && active_com === p; i++) @(negedge mclk);
    p = active_com;
    while (n < 300 && active_com === p) begin
      @(negedge mclk);
      n++;
    end
    check(n, exp);
  endtask
  // One full frame of 16 x 64 cycles; a pixel is lit for 64 of them
  task automatic frame(input logic [15:0] rows, input int cnt);
    logic [15:0] acc;
    int sum;
    acc = 0;
    sum = 0;
    repeat (4) @(negedge mclk);
    repeat (1024) begin
      @(negedge mclk);
      acc |= lit_row;
      sum += lit_cnt;
    end
    check(acc, rows);
    check(sum, cnt);
  endtask
  task automatic t_latch;
    check(lcd_control, 4'hc);
    latch_pin = 0;
    repeat (6) @(negedge mclk);
    check(edge_latched_input, 1'b1);
    latch_pin = 1;
    ctrl(4'h8);
    check(edge_latched_input, 1'b0);
    latch_pin = 0;
    repeat (6) @(negedge mclk);
    check(edge_latched_input, 1'b0);
    latch_pin = 1;
  endtask
  task automatic t_mem;
    for (int a = 'hb0; a < 'h100; a++) begin
      mem(1, 0, a[7:0], 4'h0);
      mem(1, 1, a[7:0], 4'h0);
    end
    mem(1, 0, 8'hb0, 4'h1);
    mem(1, 0, 8'hb1, 4'h8);
    mem(1, 1, 8'hb0, 4'h2);
    mem(1, 1, 8'hff, 4'ha);
    mem(0, 1, 8'hff, 4'h0);
    check({mem_hit, mem_rdata}, 5'h1a);
    mem(0, 0, 8'h7f, 4'h0);
    check({mem_hit, mem_rdata}, 5'h00);
  endtask
  task automatic t_scan;
    ctrl(4'ha);
    step_gap(64);
    frame(16'h0081, 128);
    ctrl(4'hb);
    frame(16'ha200, 192);
    ctrl(4'h8);
    step_gap(80);
  endtask
  task automatic t_off;
    ctrl(4'h2);
    step_gap(64);
    frame(16'h0000, 0);
    ctrl(4'ha);
    frame(16'h0081, 128);
    mem(0, 0, 8'hb1, 4'h0);
    check(mem_rdata, 4'h8);
  endtask
  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge mclk);
    reset = 0;
    t_latch();
    t_mem();
    t_scan();
    t_off();
    print_verdict();
  end
  // Watchdog: the tests need about 5000 cycles
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
